// file: src/sdrbms_defines.svh
// Constants for the SDRAM burst and mode sequencer: fields, codes, map.
`ifndef SDRBMS_DEFINES_SVH
`define SDRBMS_DEFINES_SVH

// ----------------------------------------------------------------------
// Mode word field positions
// ----------------------------------------------------------------------
`define SDRBMS_BL_LSB 0
`define SDRBMS_BL_MSB 2
`define SDRBMS_BT_BIT 3
`define SDRBMS_LAT_LSB 4
`define SDRBMS_LAT_MSB 6
`define SDRBMS_OPM_LSB 7
`define SDRBMS_OPM_MSB 8
`define SDRBMS_WBM_BIT 9

// ----------------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------------
`define SDRBMS_BL_ONE 3'h0
`define SDRBMS_BL_TWO 3'h1
`define SDRBMS_BL_FOUR 3'h2
`define SDRBMS_BL_EIGHT 3'h3
`define SDRBMS_BL_PAGE 3'h7
`define SDRBMS_LAT_TWO 3'h2
`define SDRBMS_LAT_THREE 3'h3
`define SDRBMS_OPM_NORMAL 2'h0
`define SDRBMS_MODE_RESET 12'h020
`define SDRBMS_PAGE_LAST 10'h3ff

// ----------------------------------------------------------------------
// Register map (byte addresses, word index in address bits 3..2)
// ----------------------------------------------------------------------
`define SDRBMS_REG_CMD 4'h0
`define SDRBMS_REG_MODE 4'h4
`define SDRBMS_REG_STATUS 4'h8
`define SDRBMS_REG_COLUMN 4'hc
`define SDRBMS_CMD_NOP 3'h0
`define SDRBMS_CMD_READ 3'h1
`define SDRBMS_CMD_WRITE 3'h2
`define SDRBMS_CMD_TERM 3'h3
`define SDRBMS_CMD_LOADMODE 3'h4

`endif

// file: src/sdrbms_pkg.sv
// Types shared by the burst and mode sequencer files.
package sdrbms_pkg;

    typedef struct packed {
        logic singleWrite;
        logic [1:0] opMode;
        logic [2:0] readLatency;
        logic interleaved;
        logic [2:0] burstLength;
    } sdrbms_mode_type;

    typedef struct packed {
        logic valid;
        logic isWrite;
        logic [9:0] column;
    } sdrbms_access_type;

endpackage : sdrbms_pkg

// file: src/sdrbms_column_gen.sv
// Column address generator for one step of a burst.
`timescale 1ns/10ps
`include "sdrbms_defines.svh"

module sdrbms_column_gen (
    input wire logic [9:0] startColumn,
    input wire logic [9:0] stepCount,
    input wire logic [2:0] burstLength,
    input wire logic interleaved,
    output logic [9:0] column
);
    // Low-bit mask selecting the position inside the block; the rest of
    // the column picks the block and never changes during the burst.
    wire [9:0] blockMask =
        (burstLength == `SDRBMS_BL_TWO) ? 10'h001 :
        (burstLength == `SDRBMS_BL_FOUR) ? 10'h003 :
        (burstLength == `SDRBMS_BL_EIGHT) ? 10'h007 :
        (burstLength == `SDRBMS_BL_PAGE) ? 10'h3ff : 10'h000;
    wire [9:0] seqOffset = 10'(startColumn + stepCount);
    wire [9:0] intOffset = startColumn ^ stepCount;
    wire useInterleave = interleaved
        && (burstLength != `SDRBMS_BL_PAGE)
        && (burstLength != `SDRBMS_BL_ONE);
    wire [9:0] offset = useInterleave ? intOffset : seqOffset;

    assign column = (startColumn & ~blockMask) | (offset & blockMask);

endmodule : sdrbms_column_gen

// file: src/sdrbms_sequencer.sv
// Burst sequencer with read latency, reached over Avalon-MM.
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "sdrbms_defines.svh"

// What this block does
// - Bursts of one, two, four, eight both orders; full page sequential only.
// - Full-page bursts run until a burst terminate or a new read or write command stops them.
// - Every access of a burst stays in a block of burst length, wrapping.
// - Block from column bits above the length; low bits give the start.
// - Full page spans 1024 columns, starts anywhere, wraps at page end.
// - Mode bit three picks sequential or interleaved order.
// - Sequential counts up modulo length; interleaved XORs start with count.
// - Length one reads exactly the given column; burst type ignored.
// - Read latency is two or three clocks.
// - Read with latency m drives after edge n+m-1, valid at n+m.
// - Normal operation needs both operating-mode bits zero.
// - Single-write bit makes writes one location, reads keep the length.
// - Command inhibit blocks new commands but lets running ones finish.
// - Mode word: length 2..0, type 3, latency 6..4, op 8..7, write 9.
module sdrbms_sequencer (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic cmdInhibit,
    output logic [9:0] accessColumn,
    output logic accessValid,
    output logic accessWrite,
    output logic dataDriveEn,
    output logic dataValid,
    output logic [9:0] dataColumn
);

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    function automatic logic [3:0] burstSize(input logic [2:0] code);
        case (code)
            `SDRBMS_BL_ONE: burstSize = 4'h1;
            `SDRBMS_BL_TWO: burstSize = 4'h2;
            `SDRBMS_BL_FOUR: burstSize = 4'h4;
            `SDRBMS_BL_EIGHT: burstSize = 4'h8;
            default: burstSize = 4'h0;
        endcase
    endfunction : burstSize

    function automatic logic lengthLegal(input logic [2:0] code);
        lengthLegal = (code == `SDRBMS_BL_PAGE) || (burstSize(code) != 4'h0);
    endfunction : lengthLegal

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} sdrbms_state_type;

    sdrbms_pkg::sdrbms_mode_type mode_q, mode_d;
    sdrbms_state_type state_q, state_d;
    logic [9:0] start_q, start_d;
    logic [9:0] step_q, step_d;
    logic [2:0] runLength_q, runLength_d;
    logic runInterleave_q, runInterleave_d;
    logic [2:0] lastCmd_q, lastCmd_d;
    logic [1:0] reserved_q, reserved_d;
    logic [31:0] readdata_q, readdata_d;
    logic ack_q;
    logic waitreq_q;
    logic [9:0] genColumn;
    sdrbms_pkg::sdrbms_access_type access_q, access_d;
    sdrbms_pkg::sdrbms_access_type pipe1_q;
    logic drive_q, valid_q;
    logic [9:0] dataCol_q;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // One wait cycle on every access keeps read data registered.
    wire busReq = (avs_read || avs_write) && !ack_q;
    // A write lands on the edge that ends its transfer, one edge after its wait
    // state ends, so a master that samples waitrequest low sees it take effect.
    wire wrTake = avs_write && ack_q;
    wire hitCmd = avs_address == `SDRBMS_REG_CMD;
    wire hitMode = avs_address == `SDRBMS_REG_MODE;
    wire hitStatus = avs_address == `SDRBMS_REG_STATUS;
    wire hitColumn = avs_address == `SDRBMS_REG_COLUMN;
    wire [2:0] cmdCode = avs_writedata[18:16];
    wire [9:0] cmdColumn = avs_writedata[9:0];
    // Command inhibit drops new commands; a running burst is untouched.
    wire cmdTake = wrTake && hitCmd && avs_byteenable[2] && !cmdInhibit;
    wire startRead = cmdTake && (cmdCode == `SDRBMS_CMD_READ);
    wire startWrite = cmdTake && (cmdCode == `SDRBMS_CMD_WRITE);
    wire terminate = cmdTake && (cmdCode == `SDRBMS_CMD_TERM);
    wire idle = state_q == ST_IDLE;
    wire loadMode = cmdTake && (cmdCode == `SDRBMS_CMD_LOADMODE) && idle;
    wire [11:0] modeWord = {2'h0, cmdColumn};

    wire [2:0] newLength = mode_q.burstLength;
    // Single-write mode forces writes to one location.
    wire [2:0] writeLength = mode_q.singleWrite ? `SDRBMS_BL_ONE
                                                : newLength;
    wire startLegal = lengthLegal(newLength);
    wire [3:0] runSize = burstSize(runLength_q);
    wire lastStep = (runLength_q == `SDRBMS_BL_PAGE)
        ? 1'b0
        : (step_q == {6'h0, runSize} - 10'h001);
    wire latThree = mode_q.readLatency == `SDRBMS_LAT_THREE;
    wire latLegal = latThree || (mode_q.readLatency == `SDRBMS_LAT_TWO);
    wire normalMode = mode_q.opMode == `SDRBMS_OPM_NORMAL;

    sdrbms_column_gen columnGen (
        .startColumn(start_q),
        .stepCount(step_q),
        .burstLength(runLength_q),
        .interleaved(runInterleave_q),
        .column(genColumn)
    );

    // ------------------------------------------------------------------
    // Burst state machine
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        start_d = start_q;
        step_d = step_q;
        runLength_d = runLength_q;
        runInterleave_d = runInterleave_q;
        access_d = '0;
        if (state_q != ST_IDLE) begin
            access_d.valid = 1'b1;
            access_d.isWrite = state_q == ST_WRITE;
            access_d.column = genColumn;
            step_d = 10'(step_q + 10'h001);
            if (lastStep) begin
                state_d = ST_IDLE;
            end
        end
        if (terminate) begin
            state_d = ST_IDLE;
            access_d = '0;
        end
        // A new command cuts the running burst short; a refused one
        // leaves whatever runs untouched.
        if (((startRead && latLegal) || startWrite) && startLegal
            && normalMode) begin
            state_d = startRead ? ST_READ : ST_WRITE;
            start_d = cmdColumn;
            step_d = 10'h000;
            runLength_d = startRead ? newLength : writeLength;
            runInterleave_d = mode_q.interleaved;
        end
    end

    // ------------------------------------------------------------------
    // Mode register and bus answers
    // ------------------------------------------------------------------
    always_comb begin
        mode_d = mode_q;
        lastCmd_d = lastCmd_q;
        reserved_d = reserved_q;
        if (loadMode) begin
            mode_d = sdrbms_pkg::sdrbms_mode_type'(modeWord[9:0]);
            reserved_d = modeWord[11:10];
        end
        if (cmdTake) begin
            lastCmd_d = cmdCode;
        end
    end

    wire [31:0] statusWord = {21'h0, !lengthLegal(mode_q.burstLength),
        !latLegal,
        !normalMode, cmdInhibit, lastCmd_q, 1'b0,
        state_q == ST_WRITE, state_q == ST_READ, !idle};
    assign readdata_d =
        hitMode ? {20'h0, reserved_q, mode_q} :
        hitStatus ? statusWord :
        hitColumn ? {22'h0, access_q.column} : 32'h0;

    // ------------------------------------------------------------------
    // Read latency pipeline
    // ------------------------------------------------------------------
    // A beat is known one cycle before its own flop shows it. Latency two
    // hands it straight to the output flops, so the data stands from the
    // edge after the command edge and is sampled valid one edge later.
    // Latency three puts one more stage in between.
    wire sdrbms_pkg::sdrbms_access_type readAccess =
        (access_d.valid && !access_d.isWrite) ? access_d : '0;
    wire sdrbms_pkg::sdrbms_access_type outStage =
        latThree ? pipe1_q : readAccess;

    // ------------------------------------------------------------------
    // Burst and mode registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // The mode only changes while idle, so a running burst never sees
    // its length or order move under it.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            mode_q <= sdrbms_pkg::sdrbms_mode_type'(10'(`SDRBMS_MODE_RESET));
        end else begin
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            reserved_q <= 2'h0;
        end else begin
            reserved_q <= reserved_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            start_q <= 10'h000;
        end else begin
            start_q <= start_d;
        end
    end

    // Ten bits so a full page can count every column before it wraps.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            step_q <= 10'h000;
        end else begin
            step_q <= step_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            runLength_q <= `SDRBMS_BL_ONE;
        end else begin
            runLength_q <= runLength_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            runInterleave_q <= 1'b0;
        end else begin
            runInterleave_q <= runInterleave_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            lastCmd_q <= `SDRBMS_CMD_NOP;
        end else begin
            lastCmd_q <= lastCmd_d;
        end
    end

    // ------------------------------------------------------------------
    // Beat and read data registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            access_q <= '0;
        end else begin
            access_q <= access_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pipe1_q <= '0;
        end else begin
            pipe1_q <= readAccess;
        end
    end

    // Drive and valid share one stage; the data word is modelled, not
    // timed, so there is no access time to wait for between them.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            drive_q <= 1'b0;
        end else begin
            drive_q <= outStage.valid;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= outStage.valid;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            dataCol_q <= 10'h000;
        end else begin
            dataCol_q <= outStage.column;
        end
    end

    // ------------------------------------------------------------------
    // Bus answer registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= busReq;
        end
    end

    // Its own flop, so the port never shows a gate's glitches.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            waitreq_q <= 1'b1;
        end else begin
            waitreq_q <= !busReq;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            readdata_q <= 32'h0;
        end else if (busReq && avs_read) begin
            readdata_q <= readdata_d;
        end
    end

    assign avs_waitrequest = waitreq_q;
    assign avs_readdata = readdata_q;
    assign accessColumn = access_q.column;
    assign accessValid = access_q.valid;
    assign accessWrite = access_q.isWrite;
    assign dataDriveEn = drive_q;
    assign dataValid = valid_q;
    assign dataColumn = dataCol_q;

endmodule : sdrbms_sequencer

// file: tb/sdrbms_seq_assertions.sv
// Port-level checks on the burst and mode sequencer.
`timescale 1ns/10ps
module sdrbms_seq_checker (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic cmdInhibit,
    input wire logic [9:0] accessColumn,
    input wire logic accessValid,
    input wire logic accessWrite,
    input wire logic dataDriveEn,
    input wire logic dataValid,
    input wire logic [9:0] dataColumn
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    wire logic newReq = (avs_read || avs_write) && avs_waitrequest;
    wire logic termCmd = !avs_waitrequest && avs_write && avs_address == 4'h0
        && avs_byteenable[2] && !cmdInhibit
        && avs_writedata[18:16] == 3'h3;
    a_ack_next_cycle: assert property (newReq |=> !avs_waitrequest)
        else $error("request not answered one cycle later");
    a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_rdata_on_ack: assert property
        (!$stable(avs_readdata) |-> !avs_waitrequest)
        else $error("read data moved outside an answer");
    a_drive_with_valid: assert property (dataDriveEn == dataValid)
        else $error("drive enable and data valid differ");
    a_data_follows_beat: assert property (dataValid |->
        (accessValid && !accessWrite && accessColumn == dataColumn)
        || ($past(accessValid) && !$past(accessWrite)
        && $past(accessColumn) == dataColumn))
        else $error("read data not with or one cycle after its beat");
    a_inhibit_blocks: assert property
        (!avs_waitrequest && avs_write && cmdInhibit && !accessValid
        |=> ##1 !accessValid)
        else $error("burst started under command inhibit");
    a_term_stops: assert property (termCmd |=> !accessValid)
        else $error("beats continue after burst terminate");
    a_reset_quiet: assert property (disable iff (1'b0)
        !resetn |=> avs_waitrequest && !accessValid && !dataValid)
        else $error("outputs active during reset");
endmodule : sdrbms_seq_checker

bind sdrbms_sequencer sdrbms_seq_checker sdrbms_seq_checker_i (.clk_sys,
    .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .cmdInhibit,
    .accessColumn, .accessValid, .accessWrite, .dataDriveEn, .dataValid,
    .dataColumn);

// file: tb/sdrbms_ctrl_model.sv
// Avalon master model of the external memory controller.
`timescale 1ns/10ps
module sdrbms_ctrl_model (
    input wire logic clk_sys,
    input wire logic go,
    input wire logic goRead,
    input wire logic [3:0] goAddr,
    input wire logic [31:0] goData,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    output logic [3:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic done,
    output logic [31:0] rdData
);
    initial begin
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        {done, rdData} = '0;
    end
    // Released address and data are inverted so no stale value looks valid.
    always @(posedge clk_sys) begin
        done <= 1'b0;
        if (avs_read || avs_write) begin
            if (!avs_waitrequest) begin
                rdData <= avs_readdata;
                {avs_read, avs_write} <= 2'h0;
                avs_address <= ~avs_address;
                avs_writedata <= ~avs_writedata;
                done <= 1'b1;
            end
        end else if (go) begin
            avs_address <= goAddr;
            avs_read <= goRead;
            avs_write <= !goRead;
            avs_writedata <= goData;
        end
    end
endmodule : sdrbms_ctrl_model

// file: tb/tb_sdram_burst_mode_sequencer.sv
// Self-checking bench for the burst and mode sequencer.
`timescale 1ns/10ps
module tb_sdram_burst_mode_sequencer;
    logic clk_sys, resetn, cmdInhibit, go, goRead, done, il;
    logic avsRead, avsWrite, waitReq, aValid, aWrite, dValid;
    logic [3:0] goAddr, avsAddr;
    logic [31:0] goData, avsWdata, avsRdata, rdData;
    logic [9:0] aCol, dCol, mode;
    logic [10:0] beatQ[$];
    logic [9:0] dataQ[$];
    int latQ[$];
    int fails, n_compared, cyc, len, lat, k;
    logic [9:0] bad[6] = '{10'h024, 10'h025, 10'h026, 10'h0a0, 10'h120,
        10'h010};
    sdrbms_sequencer sdrbms_sequencer_i (.clk_sys, .resetn,
        .avs_address(avsAddr), .avs_read(avsRead), .avs_write(avsWrite),
        .avs_writedata(avsWdata), .avs_byteenable(4'hf),
        .avs_readdata(avsRdata), .avs_waitrequest(waitReq), .cmdInhibit,
        .accessColumn(aCol), .accessValid(aValid), .accessWrite(aWrite),
        .dataDriveEn(), .dataValid(dValid), .dataColumn(dCol));
    sdrbms_ctrl_model sdrbms_ctrl_model_i (.clk_sys, .go, .goRead, .goAddr,
        .goData, .avs_waitrequest(waitReq), .avs_readdata(avsRdata),
        .avs_address(avsAddr), .avs_read(avsRead), .avs_write(avsWrite),
        .avs_writedata(avsWdata), .done, .rdData);
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic end_sim();
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    task automatic bus(input logic rd, input logic [3:0] a,
        input logic [31:0] d);
        go <= 1'b1;
        {goRead, goAddr, goData} <= {rd, a, d};
        @(posedge clk_sys);
        go <= 1'b0;
        k = 0;
        do @(posedge clk_sys); while (done !== 1'b1 && ++k < 30);
        if (k >= 30) begin
            fails++;
            end_sim();
        end
    endtask : bus
    task automatic cmd(input logic [2:0] c, input logic [9:0] col);
        bus(1'b0, 4'h0, {13'h0, c, 6'h0, col});
    endtask : cmd
    task automatic drain();
        k = 0;
        while ((beatQ.size() || dataQ.size() || latQ.size()) && ++k < 300)
            @(posedge clk_sys);
        if (k >= 300) begin
            fails++;
            end_sim();
        end
        repeat (4) @(posedge clk_sys);
    endtask : drain
    function automatic logic [9:0] colAt(input logic [9:0] s, input int i);
        logic [9:0] m;
        m = 10'(len - 1);
        if (il) return (s & ~m) | ((s ^ 10'(i)) & m);
        return (s & ~m) | ((s + 10'(i)) & m);
    endfunction : colAt
    task automatic burst(input logic rd, input logic [9:0] s, input int n);
        for (int i = 0; i < n; i++) begin
            beatQ.push_back({~rd, colAt(s, i)});
            if (rd) dataQ.push_back(colAt(s, i));
        end
        cmd(rd ? 3'h1 : 3'h2, s);
        drain();
    endtask : burst
    always @(posedge clk_sys) begin
        cyc++;
        if (resetn && aValid === 1'b1) begin
            chk("beat", {aWrite, aCol}, beatQ.size() ? beatQ.pop_front() : 11'hx);
            if (aWrite === 1'b0) latQ.push_back(cyc + lat - 2);
        end
        if (resetn && dValid === 1'b1) begin
            chk("data", dCol, dataQ.size() ? dataQ.pop_front() : 10'hx);
            chk("lat", cyc, latQ.size() ? latQ.pop_front() : 32'hx);
        end
    end
    initial begin
        void'($urandom(72));
        {resetn, cmdInhibit, go, goRead, goAddr, goData} <= '0;
        {fails, n_compared, cyc, lat} = '0;
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        bus(1'b1, 4'h4, 32'h0);
        chk("mode", rdData, 32'h20);
        for (int m = 0; m < 32; m++) begin
            il = m[2];
            len = 1 << m[1:0];
            lat = m[3] ? 3 : 2;
            mode = {m[4], 2'h0, 3'(lat), il, 1'b0, 2'(m)};
            cmd(3'h4, mode);
            bus(1'b1, 4'h4, 32'h0);
            chk("mode", rdData, {22'h0, mode});
            burst(1'b1, 10'($urandom), len);
            burst(1'b0, 10'($urandom), m[4] ? 1 : len);
        end
        // The burst is cut short, so leftover notes are dropped afterwards.
        {len, il, lat} = {32'd1024, 1'b0, 32'd2};
        cmd(3'h4, 10'h027);
        for (int i = 0; i < 40; i++) beatQ.push_back({1'b0, colAt(10'h3fe, i)});
        for (int i = 0; i < 40; i++) dataQ.push_back(colAt(10'h3fe, i));
        cmd(3'h1, 10'h3fe);
        cmd(3'h3, 10'h0);
        repeat (12) @(posedge clk_sys);
        chk("term", beatQ.size() > 0, 1);
        chk("term", aValid, 1'b0);
        beatQ.delete();
        dataQ.delete();
        latQ.delete();
        len = 8;
        cmd(3'h4, 10'h023);
        for (int i = 0; i < 8; i++) beatQ.push_back({1'b0, colAt(10'h11, i)});
        for (int i = 0; i < 8; i++) dataQ.push_back(colAt(10'h11, i));
        cmd(3'h1, 10'h11);
        cmdInhibit <= 1'b1;
        cmd(3'h3, 10'h0);
        drain();
        cmd(3'h1, 10'h40);
        repeat (6) @(posedge clk_sys);
        bus(1'b1, 4'h8, 32'h0);
        chk("status", rdData, 32'h90);
        cmdInhibit <= 1'b0;
        foreach (bad[i]) begin
            cmd(3'h4, bad[i]);
            cmd(3'h1, 10'h5);
            repeat (8) @(posedge clk_sys);
        end
        bus(1'b1, 4'h8, 32'h0);
        chk("status", rdData, 32'h210);
        chk("left", beatQ.size() + dataQ.size(), 0);
        end_sim();
    end
endmodule : tb_sdram_burst_mode_sequencer
